// >>> bench/bsp_monitor.sv
`timescale 1ns/100ps
module bsp_monitor #(
    parameter int DATA_BITS = 64
) (
    input wire logic                   mclk,    // clock
    input wire logic                   sys_rst, // sync reset
    input wire logic                   tvalid,  // word offered
    input wire logic                   tready,  // word accepted
    input wire logic [DATA_BITS-1:0]   tdata,   // payload
    input wire logic [DATA_BITS/8-1:0] tkeep,   // byte keep
    input wire logic [DATA_BITS/8-1:0] tstrb,   // byte strobe
    input wire logic                   tlast,   // end of stream
    input wire logic [0:0]             tuser,   // user sideband
    input wire logic [0:0]             tid,     // stream id
    input wire logic [0:0]             tdest    // destination
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // producer holds an offered word and its sideband
    a_hold_word: assert property (tvalid && !tready |=> tvalid && $stable(tdata))
        else $error("word changed before taken");
    a_hold_side: assert property (tvalid && !tready |=> $stable({tlast, tuser, tid, tdest}))
        else $error("sideband changed before taken");
    // valid only leaves after a handshake, and a stall ends in time
    a_drop_after_take: assert property ($fell(tvalid) |-> $past(tready))
        else $error("valid dropped without handshake");
    a_stall_bounded: assert property (tvalid && !tready |-> ##[1:40] tready)
        else $error("consumer never ready");
    // registered sink ready pauses after each take
    a_sink_pause: assert property (tvalid && tready |=> !tready)
        else $error("sink ready not registered");
    a_ready_after_rst: assert property ($fell(sys_rst) |-> ##[0:2] tready)
        else $error("sink ready late after reset");
    // full bus payload, zero padding of the small member
    a_keep_full: assert property (tvalid |-> tkeep == '1 && tstrb == '1)
        else $error("byte qualifiers not all set");
    a_pad_zero: assert property (tvalid |-> tdata[DATA_BITS-1:DATA_BITS/2+8] == '0)
        else $error("padding bits not zero");
endmodule

// >>> bench/bsp_test.sv
`timescale 1ns/100ps
module byte_aligned_stream_port_test;
    logic        mclk      = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        in_valid  = 1'b0;
    logic [31:0] in_m0     = 32'h0;
    logic [7:0]  in_m1     = 8'h0;
    logic        in_last   = 1'b0;
    logic [1:0]  in_user   = 2'h0;
    logic [1:0]  in_id     = 2'h0;
    logic [1:0]  in_dest   = 2'h0;
    logic        out_ready = 1'b1;
    logic        in_ready, rdy_s, out_valid, out_last, in_stream;
    logic [63:0] out_data;
    logic [7:0]  out_keep;
    logic [1:0]  out_user, out_id, out_dest;
    logic [70:0] exp_q[$];
    logic [63:0] exp_s[$];
    logic [64:0] sgn_word;
    int          n_mismatch = 0;
    int          comparisons = 0;

    // clock and settled ready sample for the next edge
    always #4 mclk = ~mclk;
    always @(negedge mclk) rdy_s = in_ready;

    bsp_if i_bsp_if (.mclk(mclk));
    bsp_source i_bsp_source (.mclk(mclk), .sys_rst(sys_rst), .in_valid(in_valid),
        .in_ready(in_ready), .in_m0(in_m0), .in_m1(in_m1), .in_last(in_last),
        .in_user(in_user), .in_id(in_id), .in_dest(in_dest), .tx(i_bsp_if.producer));
    bsp_sink i_bsp_sink (.mclk(mclk), .sys_rst(sys_rst), .rx(i_bsp_if.consumer),
        .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data),
        .out_keep(out_keep), .out_last(out_last), .out_user(out_user), .out_id(out_id),
        .out_dest(out_dest), .in_stream(in_stream));
    bsp_monitor i_bsp_monitor (.mclk(mclk), .sys_rst(sys_rst), .tvalid(i_bsp_if.tvalid),
        .tready(i_bsp_if.tready), .tdata(i_bsp_if.tdata), .tkeep(i_bsp_if.tkeep),
        .tstrb(i_bsp_if.tstrb), .tlast(i_bsp_if.tlast), .tuser(i_bsp_if.tuser),
        .tid(i_bsp_if.tid), .tdest(i_bsp_if.tdest));

    // signed twin: same stimulus, ready mirrored from the main link
    bsp_if i_bsp_if_signed (.mclk(mclk));
    assign i_bsp_if_signed.tready = i_bsp_if.tready;
    assign sgn_word = {i_bsp_if_signed.tvalid, i_bsp_if_signed.tdata};
    bsp_source #(.SIGNED(1'b1)) i_bsp_source_signed (.mclk(mclk), .sys_rst(sys_rst),
        .in_valid(in_valid), .in_ready(), .in_m0(in_m0), .in_m1(in_m1), .in_last(in_last),
        .in_user(in_user), .in_id(in_id), .in_dest(in_dest), .tx(i_bsp_if_signed.producer));

    // compare and count
    task automatic check(input logic [70:0] got, input logic [70:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // offer one word, hold it until the fifo takes it
    task automatic send(input logic [31:0] m0, input logic [7:0] m1, input logic l);
        int k;
        in_valid <= 1'b1;
        in_m0 <= m0;
        in_m1 <= m1;
        in_last <= l;
        in_user <= {1'b0, m0[0]};
        in_id <= {1'b0, m0[1]};
        in_dest <= {1'b0, m1[0]};
        exp_q.push_back({l, 1'b0, m0[0], 1'b0, m0[1], 1'b0, m1[0], 24'h0, m1, m0});
        exp_s.push_back({{24{m1[7]}}, m1, m0});
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (rdy_s !== 1'b1 && k < 50);
        check(rdy_s, 1'b1, "word not taken");
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // scoreboard on the user side of the sink
    always @(posedge mclk)
        if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1)
        begin
            check({out_last, out_user, out_id, out_dest, out_data}, exp_q.pop_front(), "word");
            check(out_keep, 8'hff, "keep");
        end

    // signed twin: sign-filled member slot on each link transfer
    always @(posedge mclk)
        if (!sys_rst && i_bsp_if.tvalid === 1'b1 && i_bsp_if.tready === 1'b1)
            check(sgn_word, {1'b1, exp_s.pop_front()}, "signed word");

    // main sequence
    initial
    begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        send(32'h8000_0001, 8'hff, 1'b0);
        send(32'h1234_5678, 8'h80, 1'b0);
        send(32'hffff_ffff, 8'h01, 1'b0);
        send(32'h0000_0002, 8'h7f, 1'b1);
        in_valid <= 1'b0;
        repeat (10) @(posedge mclk);
        check(in_stream, 1'b0, "stream still open");
        check(71'(exp_q.size()), 71'h0, "words lost");
        // stall the sink: fifo, output stage and sink holding all fill
        out_ready <= 1'b0;
        for (int i = 0; i < bsp_pkg::FIFO_DEPTH + 2; i++)
            send(32'(i), 8'(i), 1'(i == bsp_pkg::FIFO_DEPTH + 1));
        in_valid <= 1'b0;
        @(posedge mclk);
        check(rdy_s, 1'b0, "full fifo not refusing");
        check(in_stream, 1'b1, "stream not open");
        out_ready <= 1'b1;
        for (int k = 0; k < 100 && exp_q.size() > 0; k++)
            @(posedge mclk);
        check(71'(exp_q.size()), 71'h0, "drain incomplete");
        check(71'(exp_s.size()), 71'h0, "signed words lost");
        tally_and_finish();
    end

    // watchdog
    initial
    begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule

// >>> logic/bsp_fifo.sv
`timescale 1ns/100ps
module bsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,     // clock
    input  wire logic             sys_rst,  // sync reset
    input  wire logic             in_valid, // fill side valid
    output logic                  in_ready, // not full
    input  wire logic [WIDTH-1:0] in_data,  // fill data
    output logic                  out_valid,// not empty
    input  wire logic             out_ready,// drain side ready
    output logic      [WIDTH-1:0] out_data  // head word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } bsp_fifo_s;

    bsp_fifo_s             st;
    bsp_fifo_s             next_st;
    logic [WIDTH-1:0]      mem [DEPTH];
    logic                  push;
    logic                  pop;

    // size check at elaboration
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin
        $error("bsp_fifo: depth must be a power of two >= 2");
    end

    assign in_ready  = (st.cnt != (AW + 1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = mem[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb
    begin
        next_st = st;
        if (push)
            next_st.wp = st.wp + 1'b1;
        if (pop)
            next_st.rp = st.rp + 1'b1;
        if (push && !pop)
            next_st.cnt = st.cnt + 1'b1;
        else if (pop && !push)
            next_st.cnt = st.cnt - 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    // storage write
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[st.wp] <= in_data;
    end
endmodule

// >>> logic/bsp_if.sv
`timescale 1ns/100ps
interface bsp_if #(
    parameter int DATA_BITS = 64,
    parameter int USER_BITS = 1,
    parameter int ID_BITS   = 1,
    parameter int DEST_BITS = 1
) (
    input wire logic mclk
);
    localparam int KB = DATA_BITS / 8;
    localparam int UW = (USER_BITS > 0) ? USER_BITS : 1;
    localparam int IW = (ID_BITS > 0) ? ID_BITS : 1;
    localparam int DW = (DEST_BITS > 0) ? DEST_BITS : 1;
    logic                 tvalid;
    logic                 tready;
    logic [DATA_BITS-1:0] tdata;
    logic [KB-1:0]        tkeep;
    logic [KB-1:0]        tstrb;
    logic                 tlast;
    logic [UW-1:0]        tuser;
    logic [IW-1:0]        tid;
    logic [DW-1:0]        tdest;

    modport producer (output tvalid, tdata, tkeep, tstrb, tlast, tuser, tid, tdest,
                      input tready);
    modport consumer (input tvalid, tdata, tkeep, tstrb, tlast, tuser, tid, tdest,
                      output tready);
endinterface

// >>> logic/bsp_pkg.sv
package bsp_pkg;
    // bus width limit and byte rounding
    localparam int MAX_BITS   = 4096;
    localparam int BYTE_BITS  = 8;
    // default payload: two members, a 32-bit and an 8-bit one
    localparam int M0_BITS    = 32;
    localparam int M1_BITS    = 8;
    localparam int USER_BITS  = 1;
    localparam int ID_BITS    = 1;
    localparam int DEST_BITS  = 1;
    localparam int FIFO_DEPTH = 16;

    // round a width up to whole bytes
    function automatic int byte_round(input int bits);
        byte_round = ((bits + BYTE_BITS - 1) / BYTE_BITS) * BYTE_BITS;
    endfunction

    // member slot: largest member rounded to bytes
    function automatic int slot_bits(input int a, input int b);
        slot_bits = byte_round((a > b) ? a : b);
    endfunction
endpackage

// >>> logic/bsp_sink.sv
`timescale 1ns/100ps
module bsp_sink #(
    parameter int DATA_BITS = 2 * bsp_pkg::slot_bits(bsp_pkg::M0_BITS, bsp_pkg::M1_BITS),
    parameter int USER_BITS = bsp_pkg::USER_BITS,
    parameter int ID_BITS   = bsp_pkg::ID_BITS,
    parameter int DEST_BITS = bsp_pkg::DEST_BITS
) (
    input  wire logic                 mclk,      // clock
    input  wire logic                 sys_rst,   // sync reset
    bsp_if.consumer                   rx,        // incoming stream
    input  wire logic                 out_ready, // user accepts word
    output logic                      out_valid, // word held
    output logic [DATA_BITS-1:0]      out_data,  // payload
    output logic [DATA_BITS/8-1:0]    out_keep,  // valid byte mask
    output logic                      out_last,  // last word
    output logic [USER_BITS:0]        out_user,  // user sideband
    output logic [ID_BITS:0]          out_id,    // stream id
    output logic [DEST_BITS:0]        out_dest,  // destination
    output logic                      in_stream  // between first and last word
);
    localparam int KB = DATA_BITS / 8;
    localparam int UW = (USER_BITS > 0) ? USER_BITS : 1;
    localparam int IW = (ID_BITS > 0) ? ID_BITS : 1;
    localparam int DW = (DEST_BITS > 0) ? DEST_BITS : 1;

    // width check at elaboration
    if (DATA_BITS > bsp_pkg::MAX_BITS || DATA_BITS % 8 != 0)
    begin
        $error("bsp_sink: bad data width");
    end

    typedef struct packed {
        logic                 valid;
        logic                 rdy;
        logic                 busy;
        logic [DATA_BITS-1:0] data;
        logic [KB-1:0]        keep;
        logic                 last;
        logic [UW-1:0]        user;
        logic [IW-1:0]        id;
        logic [DW-1:0]        dest;
    } bsp_snk_s;

    bsp_snk_s st;
    bsp_snk_s next_st;
    logic     take;

    assign take = rx.tvalid && st.rdy;

    // one holding word, ready registered from its state
    always_comb
    begin
        next_st = st;
        if (st.valid && out_ready)
            next_st.valid = 1'b0;
        if (take)
        begin
            next_st.valid = 1'b1;
            next_st.data  = rx.tdata;
            next_st.keep  = rx.tkeep & rx.tstrb;
            next_st.last  = rx.tlast;
            next_st.user  = rx.tuser;
            next_st.id    = rx.tid;
            next_st.dest  = rx.tdest;
            next_st.busy  = !rx.tlast;
        end
        next_st.rdy = !next_st.valid;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign rx.tready = st.rdy;
    assign out_valid = st.valid;
    assign out_data  = st.data;
    assign out_keep  = st.keep;
    assign out_last  = st.last;
    assign out_user  = (USER_BITS + 1)'(st.user);
    assign out_id    = (ID_BITS + 1)'(st.id);
    assign out_dest  = (DEST_BITS + 1)'(st.dest);
    assign in_stream = st.busy;
endmodule

// >>> logic/bsp_source.sv
`timescale 1ns/100ps
// Operation
// - port carries data one way only
// - data width rounded up to bytes
// - pad bits sign or zero extended
// - struct kept whole, largest-member slots
// - nested stream member gets own port
// - data bus at most 4096 bits
// - all-byte members packed without padding; code still pads each member to the largest-member slot
// - smaller members padded to largest width
// - one aggregated payload, one port
// - one full word per transfer cycle
// - transfer only on valid and ready
// - last marker ends stream, consumer waits
// - user sideband travels with each word
// - keep and strobe mark valid bytes
// - id and destination label each transfer
// - data, valid, ready registered at boundary
// - sideband registered with data
// - zero-width sideband signals omitted; code keeps them one bit wide, driven zero
module bsp_source #(
    parameter int  M0_BITS   = bsp_pkg::M0_BITS,
    parameter int  M1_BITS   = bsp_pkg::M1_BITS,
    parameter bit  SIGNED    = 1'b0,
    parameter int  USER_BITS = bsp_pkg::USER_BITS,
    parameter int  ID_BITS   = bsp_pkg::ID_BITS,
    parameter int  DEST_BITS = bsp_pkg::DEST_BITS,
    parameter int  DEPTH     = bsp_pkg::FIFO_DEPTH,
    parameter int  SLOT      = bsp_pkg::slot_bits(M0_BITS, M1_BITS),
    parameter int  DATA_BITS = 2 * SLOT
) (
    input  wire logic                 mclk,     // clock
    input  wire logic                 sys_rst,  // sync reset
    input  wire logic                 in_valid, // user word valid
    output logic                      in_ready, // fifo has room
    input  wire logic [M0_BITS-1:0]   in_m0,    // first member
    input  wire logic [M1_BITS-1:0]   in_m1,    // second member
    input  wire logic                 in_last,  // final word of stream
    input  wire logic [USER_BITS:0]   in_user,  // user sideband, low bits used
    input  wire logic [ID_BITS:0]     in_id,    // stream id, low bits used
    input  wire logic [DEST_BITS:0]   in_dest,  // destination, low bits used
    bsp_if.producer                   tx        // outgoing stream
);
    localparam int KB = DATA_BITS / bsp_pkg::BYTE_BITS;
    localparam int UW = (USER_BITS > 0) ? USER_BITS : 1;
    localparam int IW = (ID_BITS > 0) ? ID_BITS : 1;
    localparam int DW = (DEST_BITS > 0) ? DEST_BITS : 1;
    localparam int FW = DATA_BITS + 1 + UW + IW + DW;

    // width checks at elaboration
    if (DATA_BITS > bsp_pkg::MAX_BITS)
    begin
        $error("bsp_source: data bus wider than limit");
    end
    if (DATA_BITS % bsp_pkg::BYTE_BITS != 0)
    begin
        $error("bsp_source: data bus not whole bytes");
    end
    if (SLOT < M0_BITS || SLOT < M1_BITS)
    begin
        $error("bsp_source: slot narrower than a member");
    end

    typedef struct packed {
        logic          valid;
        logic [DATA_BITS-1:0] data;
        logic          last;
        logic [UW-1:0] user;
        logic [IW-1:0] id;
        logic [DW-1:0] dest;
    } bsp_src_s;

    bsp_src_s           st;
    bsp_src_s           next_st;
    logic [SLOT-1:0]    slot0;
    logic [SLOT-1:0]    slot1;
    logic [FW-1:0]      pack;
    logic [FW-1:0]      head;
    logic               head_valid;
    logic               head_take;

    // byte-rounded slots with sign or zero fill
    always_comb
    begin
        slot0 = SLOT'(M0_BITS'(in_m0));
        slot1 = SLOT'(M1_BITS'(in_m1));
        if (SIGNED)
        begin
            slot0 = SLOT'($signed(in_m0));
            slot1 = SLOT'($signed(in_m1));
        end
    end

    // whole payload on one port, member 0 in low slot
    assign pack = {slot1, slot0, in_last,
                   (USER_BITS > 0) ? in_user[UW-1:0] : {UW{1'b0}},
                   (ID_BITS > 0)   ? in_id[IW-1:0]   : {IW{1'b0}},
                   (DEST_BITS > 0) ? in_dest[DW-1:0] : {DW{1'b0}}};

    bsp_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) i_bsp_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (pack),
        .out_valid (head_valid),
        .out_ready (head_take),
        .out_data  (head)
    );

    // output stage refills when empty or being accepted
    assign head_take = head_valid && (!st.valid || tx.tready);

    always_comb
    begin
        next_st = st;
        if (st.valid && tx.tready)
            next_st.valid = 1'b0;
        if (head_take)
        begin
            next_st.valid = 1'b1;
            {next_st.data, next_st.last, next_st.user, next_st.id, next_st.dest} = head;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    // outputs straight from the registered stage, keep and strobe tied high
    assign tx.tvalid = st.valid;
    assign tx.tdata  = st.data;
    assign tx.tkeep  = {KB{1'b1}};
    assign tx.tstrb  = {KB{1'b1}};
    assign tx.tlast  = st.last;
    assign tx.tuser  = st.user;
    assign tx.tid    = st.id;
    assign tx.tdest  = st.dest;
endmodule
